/* rtl/fcp_command_phases.sv */
// command, execution and result phases of the disk controller commands
`timescale 1ns/1ps
module fcp_command_phases
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // host byte channel
  input wire logic wr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic busy_o,
  // drive side
  input wire logic [7:0] drive_status_i,
  input wire logic id_valid_i,
  input wire fcp_id_t id_i,
  input wire logic [7:0] id_st1_i,
  input wire logic [7:0] id_st2_i,
  output fcp_step_t step_o,
  output logic id_req_o,
  output logic density_o,
  // loose settings from other commands
  input wire logic [7:0] count_i,
  input wire logic [7:0] perp_i
);

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PARAM = 5'b00010,
    ST_SEEK = 5'b00100,
    ST_READID = 5'b01000,
    ST_RESULT = 5'b10000
  } fcp_state_t;

  fcp_state_t state_q;
  logic [7:0] opcode_q;
  logic [7:0] sel_q;
  logic [1:0] need_q;
  logic [7:0] cyl_q [4];
  logic [7:0] spec1_q;
  logic [7:0] spec2_q;
  logic [7:0] config_q;
  logic [7:0] precomp_start_track_q;
  logic [7:0] last_st0_q;
  logic [7:0] last_cyl_q;
  logic [7:0] queue_q [FCP_QUEUE_DEPTH];
  logic [3:0] qlen_q;
  logic [3:0] qidx_q;
  logic seek_start_q;
  logic [7:0] seek_target_q;
  logic seek_busy;
  logic [7:0] seek_cyl;

  function automatic logic [1:0] param_count(input logic [7:0] op);
    if (op[FCP_REL_BIT] && op[4:0] == FCP_OP_SEEK)
      return 2'd2;
    case (op[4:0])
      FCP_OP_SPECIFY: return 2'd2;
      FCP_OP_SENSE_DRV: return 2'd1;
      FCP_OP_SEEK: return 2'd2;
      FCP_OP_CONFIGURE: return 2'd3;
      FCP_OP_READ_ID: return 2'd1;
      default: return 2'd0;
    endcase
  endfunction

  function automatic logic known(input logic [7:0] op);
    case (op)
      {3'b000, FCP_OP_SENSE_INT}, {3'b000, FCP_OP_SPECIFY},
      {3'b000, FCP_OP_SENSE_DRV}, {3'b000, FCP_OP_SEEK},
      {3'b000, FCP_OP_CONFIGURE}, {3'b000, FCP_OP_DUMPREG},
      {3'b000, FCP_OP_READ_ID}, {3'b010, FCP_OP_READ_ID},
      {3'b100, FCP_OP_SEEK}, {3'b110, FCP_OP_SEEK}: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  fcp_stepper u_stepper (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(seek_start_q),
    .drive_i(sel_q[1:0]),
    .from_i(cyl_q[sel_q[1:0]]),
    .to_i(seek_target_q),
    .busy_o(seek_busy),
    .cyl_o(seek_cyl),
    .step_o(step_o)
  );

  // ************************************************************
  // phase sequencing
  // ************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= ST_IDLE;
      opcode_q <= 8'h00;
      sel_q <= 8'h00;
      need_q <= 2'd0;
      qlen_q <= 4'd0;
      qidx_q <= 4'd0;
      seek_start_q <= 1'b0;
      seek_target_q <= 8'h00;
      spec1_q <= FCP_RST_SPEC1;
      spec2_q <= FCP_RST_SPEC2;
      config_q <= FCP_RST_CONFIG;
      precomp_start_track_q <= FCP_RST_PRECOMP_START_TRACK;
      last_st0_q <= FCP_NO_SEEK_STATUS;
      last_cyl_q <= 8'h00;
      id_req_o <= 1'b0;
      density_o <= 1'b0;
      busy_o <= 1'b0;
      for (int i = 0; i < 4; i++)
        cyl_q[i] <= 8'h00;
      for (int i = 0; i < FCP_QUEUE_DEPTH; i++)
        queue_q[i] <= 8'h00;
    end
    else
    begin
      seek_start_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          qidx_q <= 4'd0;
          if (wr_i)
          begin
            opcode_q <= wr_data_i;
            need_q <= param_count(wr_data_i);
            busy_o <= 1'b1;
            if (!known(wr_data_i))
            begin
              queue_q[0] <= FCP_INVALID_STATUS;
              qlen_q <= 4'd1;
              state_q <= ST_RESULT;
            end
            else if (wr_data_i[4:0] == FCP_OP_SENSE_INT)
            begin
              queue_q[0] <= last_st0_q;
              queue_q[1] <= last_cyl_q;
              qlen_q <= 4'd2;
              last_st0_q <= FCP_NO_SEEK_STATUS;
              state_q <= ST_RESULT;
            end
            else if (wr_data_i[4:0] == FCP_OP_DUMPREG)
            begin
              for (int i = 0; i < 4; i++)
                queue_q[i] <= cyl_q[i];
              queue_q[4] <= spec1_q;
              queue_q[5] <= spec2_q;
              queue_q[6] <= count_i;
              queue_q[7] <= perp_i;
              queue_q[8] <= config_q;
              queue_q[9] <= precomp_start_track_q;
              qlen_q <= 4'(FCP_DUMP_LEN);
              state_q <= ST_RESULT;
            end
            else
              state_q <= ST_PARAM;
          end
          else
            busy_o <= 1'b0;
        end
        ST_PARAM:
          if (wr_i)
          begin
            need_q <= need_q - 2'd1;
            if (need_q == param_count(opcode_q))
              sel_q <= wr_data_i;
            if (opcode_q[4:0] == FCP_OP_SPECIFY)
            begin
              if (need_q == 2'd2)
                spec1_q <= wr_data_i;
              else
                spec2_q <= wr_data_i;
            end
            if (opcode_q[4:0] == FCP_OP_CONFIGURE)
            begin
              if (need_q == 2'd2)
                config_q <= wr_data_i;
              else if (need_q == 2'd1)
                precomp_start_track_q <= wr_data_i;
            end
            if (need_q == 2'd1)
            begin
              case (opcode_q[4:0])
                FCP_OP_SENSE_DRV:
                begin
                  // no execution phase
                  queue_q[0] <= drive_status_i;
                  qlen_q <= 4'd1;
                  state_q <= ST_RESULT;
                end
                FCP_OP_SEEK:
                begin
                  if (opcode_q[FCP_REL_BIT])
                    seek_target_q <= opcode_q[FCP_DIR_BIT] ?
                      cyl_q[sel_q[1:0]] + wr_data_i :
                      cyl_q[sel_q[1:0]] - wr_data_i;
                  else
                    seek_target_q <= wr_data_i;
                  seek_start_q <= 1'b1;
                  state_q <= ST_SEEK;
                end
                FCP_OP_READ_ID:
                begin
                  density_o <= opcode_q[FCP_DENS_BIT];
                  id_req_o <= 1'b1;
                  state_q <= ST_READID;
                end
                default:
                begin
                  busy_o <= 1'b0;
                  state_q <= ST_IDLE;
                end
              endcase
            end
          end
        ST_SEEK:
          // the stepper starts one cycle after the request
          if (!seek_start_q && !seek_busy)
          begin
            cyl_q[sel_q[1:0]] <= seek_cyl;
            last_st0_q <= FCP_SEEK_END_STATUS | {5'h00, sel_q[2:0]};
            last_cyl_q <= seek_cyl;
            busy_o <= 1'b0;
            state_q <= ST_IDLE;
          end
        ST_READID:
          if (id_valid_i)
          begin
            id_req_o <= 1'b0;
            queue_q[0] <= {5'h00, sel_q[2:0]};
            queue_q[1] <= id_st1_i;
            queue_q[2] <= id_st2_i;
            queue_q[3] <= id_i.cylinder;
            queue_q[4] <= id_i.head;
            queue_q[5] <= id_i.sector;
            queue_q[6] <= id_i.size_code;
            qlen_q <= 4'(FCP_ID_LEN);
            state_q <= ST_RESULT;
          end
        ST_RESULT:
          if (rd_i)
          begin
            if (qidx_q + 4'd1 >= qlen_q)
            begin
              busy_o <= 1'b0;
              state_q <= ST_IDLE;
            end
            qidx_q <= qidx_q + 4'd1;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // result byte presented to the host
  // ************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= (state_q == ST_RESULT) && !(rd_i && rd_valid_o &&
        qidx_q + 4'd1 >= qlen_q);
      rd_data_o <= queue_q[(rd_i && rd_valid_o && qidx_q + 4'd1 < qlen_q) ?
        qidx_q + 4'd1 : qidx_q];
    end
  end

endmodule

/* rtl/fcp_pkg.sv */
// package: opcodes, field positions, reset values and timing for the command block
package fcp_pkg;

  // ************************************************************
  // opcodes, compared on the low five bits of the first byte
  // ************************************************************
  localparam logic [4:0] FCP_OP_SENSE_INT = 5'h08;
  localparam logic [4:0] FCP_OP_SPECIFY = 5'h03;
  localparam logic [4:0] FCP_OP_SENSE_DRV = 5'h04;
  localparam logic [4:0] FCP_OP_SEEK = 5'h0F;
  localparam logic [4:0] FCP_OP_CONFIGURE = 5'h13;
  localparam logic [4:0] FCP_OP_DUMPREG = 5'h0E;
  localparam logic [4:0] FCP_OP_READ_ID = 5'h0A;
  localparam int FCP_REL_BIT = 7;
  localparam int FCP_DIR_BIT = 6;
  localparam int FCP_DENS_BIT = 6;
  localparam logic [7:0] FCP_INVALID_STATUS = 8'h80;
  localparam logic [7:0] FCP_SEEK_END_STATUS = 8'h20;
  localparam logic [7:0] FCP_NO_SEEK_STATUS = 8'h80;

  // ************************************************************
  // parameter field positions
  // ************************************************************
  localparam int FCP_HEAD_BIT = 2;
  localparam int FCP_NON_DMA_BIT = 0;
  localparam int FCP_LOCK_BIT = 7;

  // ************************************************************
  // reset values and sizes
  // ************************************************************
  localparam logic [7:0] FCP_RST_SPEC1 = 8'h00;
  localparam logic [7:0] FCP_RST_SPEC2 = 8'h00;
  localparam logic [7:0] FCP_RST_CONFIG = 8'h20;
  localparam logic [7:0] FCP_RST_PRECOMP_START_TRACK = 8'h00;
  localparam int FCP_DUMP_LEN = 10;
  localparam int FCP_ID_LEN = 7;
  localparam int FCP_QUEUE_DEPTH = 10;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int FCP_CLK_MHZ = 10;
  localparam int FCP_STEP_US = 3;
  localparam int FCP_STEP_CYCLES = FCP_STEP_US * FCP_CLK_MHZ;

  // captured sector ID from the read channel
  typedef struct packed {
    logic [7:0] cylinder;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size_code;
  } fcp_id_t;

  // per-drive head-step request to the drive side
  typedef struct packed {
    logic valid;
    logic [1:0] drive;
    logic dir_in;
  } fcp_step_t;

endpackage

/* rtl/fcp_stepper.sv */
// head stepper: issues step pulses until the target cylinder is reached
`timescale 1ns/1ps
module fcp_stepper
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // request
  input wire logic start_i,
  input wire logic [1:0] drive_i,
  input wire logic [7:0] from_i,
  input wire logic [7:0] to_i,
  // progress
  output logic busy_o,
  output logic [7:0] cyl_o,
  output fcp_step_t step_o
);

  logic [7:0] target_q;
  logic [$clog2(FCP_STEP_CYCLES+1)-1:0] wait_q;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy_o <= 1'b0;
      cyl_o <= 8'h00;
      target_q <= 8'h00;
      wait_q <= '0;
      step_o <= '0;
    end
    else if (start_i)
    begin
      busy_o <= 1'b1;
      cyl_o <= from_i;
      target_q <= to_i;
      wait_q <= '0;
      step_o <= '0;
      step_o.drive <= drive_i;
    end
    else if (busy_o)
    begin
      step_o.valid <= 1'b0;
      if (wait_q != '0)
        wait_q <= wait_q - 1'b1;
      else if (cyl_o == target_q)
        busy_o <= 1'b0;
      else
      begin
        // one step per step period, direction from the sign of the gap
        step_o.valid <= 1'b1;
        step_o.dir_in <= target_q > cyl_o;
        cyl_o <= (target_q > cyl_o) ? cyl_o + 8'h01 : cyl_o - 8'h01;
        wait_q <= ($clog2(FCP_STEP_CYCLES+1))'(FCP_STEP_CYCLES);
      end
    end
  end

endmodule

/* dv/fcp_drive_model.sv */
// drive-side model: counts head steps, answers read-ID with a fixed sector ID
`timescale 1ns/1ps
module fcp_drive_model
  import fcp_pkg::*;
#(
  parameter int ID_DELAY = 20
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // from the controller
  input wire fcp_step_t step_i,
  input wire logic id_req_i,
  // to the controller, and the step count to the testbench
  output logic [7:0] drive_status_o,
  output logic id_valid_o,
  output fcp_id_t id_o,
  output logic [7:0] st1_o,
  output logic [7:0] st2_o,
  output int n_steps_o
);
  localparam fcp_id_t ID_VAL = 32'h05010902;
  int wait_q;
  logic done_q;
  assign drive_status_o = 8'h35;
  // outside the pulse the fields are not held: show their inverse
  assign id_o = id_valid_o ? ID_VAL : ~ID_VAL;
  assign st1_o = id_valid_o ? 8'h11 : 8'hEE;
  assign st2_o = id_valid_o ? 8'h22 : 8'hDD;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      n_steps_o <= 0;
    else if (step_i.valid)
      n_steps_o <= n_steps_o + 1;
  end
  // one ID per request: the first good field ends the search
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wait_q <= 0;
      done_q <= 1'b0;
      id_valid_o <= 1'b0;
    end
    else
    begin
      id_valid_o <= id_req_i && !done_q && wait_q == ID_DELAY;
      wait_q <= (id_req_i && !done_q) ? wait_q + 1 : 0;
      done_q <= id_req_i && (done_q || wait_q == ID_DELAY);
    end
  end
endmodule

/* dv/fcp_command_phases_chk.sv */
// checker for the command block's host and drive ports
`timescale 1ns/1ps
module fcp_command_phases_chk
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // host side
  input wire logic wr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic busy_o,
  // drive side
  input wire logic id_valid_i,
  input wire fcp_step_t step_o,
  input wire logic id_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic first_w;
  assign first_w = wr_i && !busy_o;
  a_sense_int_lat:
    assert property (first_w && wr_data_i == 8'h08 |=> !rd_valid_o ##1 rd_valid_o)
    else $error("sense status not offered on time");
  a_dump_lat:
    assert property (first_w && wr_data_i == 8'h0E |=> !rd_valid_o ##1 rd_valid_o)
    else $error("dump bytes not offered on time");
  a_invalid_stat:
    assert property (first_w && (wr_data_i == 8'h00 || wr_data_i == 8'h1F)
      |=> !rd_valid_o ##1 (rd_valid_o && rd_data_o == 8'h80))
    else $error("unknown command did not return 80");
  a_seek_silent:
    assert property (first_w && (wr_data_i == 8'h0F || wr_data_i == 8'h8F ||
      wr_data_i == 8'hCF) |=> !rd_valid_o [*8])
    else $error("seek offered a result byte");
  a_step_space:
    assert property (step_o.valid |-> busy_o ##1 !step_o.valid [*8])
    else $error("step pulses too close or outside a command");
  a_id_result:
    assert property (id_req_o && id_valid_i |=> !rd_valid_o ##1 rd_valid_o)
    else $error("read-ID result not offered on time");
  a_id_wait:
    assert property (id_req_o && !id_valid_i |=> !rd_valid_o)
    else $error("read-ID result before an ID was captured");
  a_rd_stands:
    assert property (rd_valid_o && !rd_i |=> rd_valid_o && $stable(rd_data_o))
    else $error("result byte changed before it was read");
  a_rd_busy:
    assert property (rd_valid_o |-> busy_o)
    else $error("result offered while not busy");
  c_sense: cover property (first_w && wr_data_i == 8'h08 ##2 rd_valid_o);
  c_step: cover property (step_o.valid);
  c_id: cover property (id_req_o && id_valid_i);
endmodule
bind fcp_command_phases fcp_command_phases_chk u_chk (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .wr_i(wr_i), .wr_data_i(wr_data_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .busy_o(busy_o),
  .id_valid_i(id_valid_i), .step_o(step_o), .id_req_o(id_req_o));

/* dv/tb_top.sv */
// testbench: command sequences through the host byte channel
`timescale 1ns/1ps
module tb_top;
  import fcp_pkg::*;
  logic clk_i, reset_n_i, wr_i, rd_i, rd_valid_o, busy_o, id_valid_i;
  logic id_req_o, density_o;
  logic [7:0] wr_data_i, rd_data_o, drive_status_i, id_st1_i, id_st2_i;
  logic [7:0] count_i, perp_i;
  logic [7:0] d [10];
  fcp_id_t id_i;
  fcp_step_t step_o;
  int failures, n_compared, steps;
  fcp_command_phases u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .wr_i(wr_i), .wr_data_i(wr_data_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .busy_o(busy_o), .drive_status_i(drive_status_i),
    .id_valid_i(id_valid_i), .id_i(id_i), .id_st1_i(id_st1_i),
    .id_st2_i(id_st2_i), .step_o(step_o), .id_req_o(id_req_o),
    .density_o(density_o), .count_i(count_i), .perp_i(perp_i));
  fcp_drive_model u_drv (.clk_i(clk_i), .reset_n_i(reset_n_i), .step_i(step_o),
    .id_req_i(id_req_o), .drive_status_o(drive_status_i),
    .id_valid_o(id_valid_i), .id_o(id_i), .st1_o(id_st1_i), .st2_o(id_st2_i),
    .n_steps_o(steps));
  always #50 clk_i = ~clk_i;
  task automatic stop_test();
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b);
    wr_data_i = b;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
    @(negedge clk_i);
  endtask
  // reads n bytes in order against d; never strobes an empty channel
  task automatic rds(input int n);
    int t;
    for (int i = 0; i < n; i++)
    begin
      t = 0;
      while (rd_valid_o !== 1'b1 && t < 100)
      begin
        @(negedge clk_i);
        t++;
      end
      chk({7'h00, rd_valid_o}, 8'h01);
      chk(rd_data_o, d[i]);
      rd_i = rd_valid_o;
      @(negedge clk_i);
      rd_i = 1'b0;
    end
  endtask
  task automatic idle();
    int t;
    t = 0;
    while (busy_o !== 1'b0 && t < 400)
    begin
      @(negedge clk_i);
      t++;
    end
    chk({6'h00, busy_o, rd_valid_o}, 8'h00);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    stop_test();
  end
  initial
  begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    wr_data_i = 8'h00;
    count_i = 8'h4C;
    perp_i = 8'h81;
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'b1;
    idle();
    wr(8'h0E);
    d = '{8'h00, 8'h00, 8'h00, 8'h00, FCP_RST_SPEC1, FCP_RST_SPEC2, 8'h4C,
      8'h81, FCP_RST_CONFIG, FCP_RST_PRECOMP_START_TRACK};
    rds(10);
    idle();
    wr(8'h03);
    wr(8'hA5);
    wr(8'h3B);
    idle();
    wr(8'h13);
    wr(8'h00);
    wr(8'h5A);
    wr(8'h07);
    idle();
    wr(8'h0F);
    wr(8'h01);
    wr(8'h03);
    idle();
    chk(8'(steps), 8'h03);
    wr(8'h08);
    d[0] = FCP_SEEK_END_STATUS | 8'h01;
    d[1] = 8'h03;
    rds(2);
    idle();
    // direction bit set steps toward higher cylinders
    wr(8'hCF);
    wr(8'h01);
    wr(8'h02);
    idle();
    chk(8'(steps), 8'h05);
    wr(8'h0E);
    d = '{8'h00, 8'h05, 8'h00, 8'h00, 8'hA5, 8'h3B, 8'h4C, 8'h81, 8'h5A,
      8'h07};
    rds(10);
    idle();
    // direction bit clear steps toward lower cylinders
    wr(8'h8F);
    wr(8'h01);
    wr(8'h01);
    idle();
    chk(8'(steps), 8'h06);
    wr(8'h08);
    d[0] = FCP_SEEK_END_STATUS | 8'h01;
    d[1] = 8'h04;
    rds(2);
    idle();
    wr(8'h04);
    wr(8'h06);
    d[0] = 8'h35;
    rds(1);
    idle();
    for (int i = 0; i < 2; i++)
    begin
      wr({1'b0, i[0], 6'h0A});
      wr(8'(2 + i));
      d = '{8'(2 + i), 8'h11, 8'h22, 8'h05, 8'h01, 8'h09, 8'h02, 8'h00,
        8'h00, 8'h00};
      rds(7);
      chk({7'h00, density_o}, 8'(i));
      idle();
    end
    foreach (d[i])
      d[i] = FCP_INVALID_STATUS;
    wr(8'h00);
    rds(1);
    idle();
    wr(8'h1F);
    rds(1);
    idle();
    stop_test();
  end
endmodule
